// file: rtl/crs_exec.v
// Executor for return-stack and control-flow instructions, AXI4-Lite slave
// Assumes one clock aclk, synchronous active-low aresetn, software feeds opcodes
//
// Operation
// [RL1] The discard opcode drops the top stack entry, leaves flags alone, and is one word.
// [RL2] After a discard the top shows the entry pushed just before the dropped one.
// [RL3] The push opcode pushes PC plus 2 as new top in one cycle without touching flags.
// [RL4] On a push the old top moves one level down, just below the new top.
// [RL5] The relative call pushes PC plus 2 first and takes two cycles, the second idle.
// [RL6] The relative call loads PC with PC plus 2 plus twice its signed 11-bit offset.
// [RL7] The soft reset opcode resets, in the second phase, all state as the master clear does; the AXI channel registers keep their state.
// [RL8] Return from interrupt pops the top into PC, keeps the PC latches, takes two cycles.
// [RL9] Return from interrupt sets either the high or the low global interrupt enable, chosen by ret_sets_low, never both.
// [RL10] With its shadow bit set it restores working, flags and bank select from shadows.
// [RL11] Return with literal loads W with the literal and pops PC in phase four, two cycles.
// [RL12] Return with literal loads PC from the top and leaves the PC high latch alone.
// [RL13] Return from subroutine pops into PC over two cycles, restoring shadows if bit set.
// [RL14] The stack is a LIFO with pointer, push increments, pop decrements, top readable.
// [RL15] The second cycle of each two-cycle opcode is idle and writes no register.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "crs_exec_consts.vh"

module crs_exec (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // Sign-extended doubled call offset
  function [`CRS_PC_W-1:0] call_disp;
    input [10:0] n;
    begin
      call_disp = {{9{n[10]}}, n, 1'b0};
    end
  endfunction

  // Opcodes that take a second, idle cycle
  function is_two_cycle;
    input [15:0] op;
    begin
      is_two_cycle = (op[15:11] == `CRS_OP_RCALL5) ||
                     (op[15:1] == `CRS_OP_RETFIE15) ||
                     (op[15:1] == `CRS_OP_RETURN15) ||
                     (op[15:8] == `CRS_OP_RETLW8);
    end
  endfunction

  // Core state
  reg [15:0] instr;
  reg busy;
  reg [1:0] phase;
  reg second;
  reg [`CRS_PC_W-1:0] pc;
  reg [7:0] working_reg;
  reg [7:0] flags;
  reg [7:0] bank_select_reg;
  reg [7:0] working_reg_shadow;
  reg [7:0] flags_shadow;
  reg [7:0] bank_select_shadow;
  reg high_prio_global_int_en;
  reg low_prio_global_int_en;
  reg ret_sets_low;
  reg [7:0] pc_high_latch;
  reg [7:0] pc_upper_latch;
  reg [`CRS_PC_W-1:0] stack [0:`CRS_STACK_DEPTH-1];
  reg [`CRS_SP_W-1:0] sp;

  // AXI state
  reg aw_have;
  reg w_have;
  reg [7:0] aw_addr;
  reg [31:0] w_data;

  wire op_pop = (instr == `CRS_OP_POP);
  wire op_push = (instr == `CRS_OP_PUSH);
  wire op_reset = (instr == `CRS_OP_RESET);
  wire op_relative_call_op = (instr[15:11] == `CRS_OP_RCALL5);
  wire op_interrupt_return_op = (instr[15:1] == `CRS_OP_RETFIE15);
  wire op_return = (instr[15:1] == `CRS_OP_RETURN15);
  wire op_literal_return_op = (instr[15:8] == `CRS_OP_RETLW8);
  wire op_ret_any = op_interrupt_return_op || op_return || op_literal_return_op;
  wire shadow_sel = instr[0];

  wire first_cyc = busy && !second;
  wire at_q2 = first_cyc && (phase == `CRS_PH_Q2);
  wire at_q4 = first_cyc && (phase == `CRS_PH_Q4);
  wire at_q3b = first_cyc && (phase == `CRS_PH_Q3);

  wire soft_rst = at_q2 && op_reset; // see [RL7]
  wire do_push = at_q2 && (op_push || op_relative_call_op); // see [RL3] see [RL5]
  wire do_pop = (at_q3b && op_pop) || (at_q4 && op_ret_any); // see [RL1] see [RL8]

  wire [`CRS_SP_W-1:0] sp_up = sp + 5'h01;
  wire [`CRS_SP_W-1:0] sp_dn = sp - 5'h01;
  wire [`CRS_PC_W-1:0] pc_plus2 = pc + 21'h000002;
  wire [`CRS_PC_W-1:0] stack_top_value = (sp == 5'h00) ? `CRS_RST_PC : stack[sp]; // see [RL14]

  // Program counter loaded at the fourth phase
  reg [`CRS_PC_W-1:0] next_pc;
  always @* begin
    next_pc = pc_plus2; // see [RL1] see [RL3]
    if (op_ret_any) begin
      next_pc = stack_top_value; // see [RL8] see [RL12] see [RL13]
    end else if (op_relative_call_op) begin
      next_pc = pc_plus2 + call_disp(instr[10:0]); // see [RL6]
    end
  end

  // Write path decode
  wire wr_fire = aw_have && w_have && !s_axi_bvalid;
  wire wr_map = (aw_addr[1:0] == 2'h0) && (aw_addr <= `CRS_OFF_LATCH);
  wire wr_ro = (aw_addr == `CRS_OFF_STAT) || (aw_addr == `CRS_OFF_SPTR);
  wire wr_ok = wr_map && !wr_ro && !busy;
  wire sw_we = wr_fire && wr_ok;
  wire lane0 = s_axi_wstrb[0];
  wire [7:0] wb = w_data[7:0];

  assign s_axi_awready = !aw_have;
  assign s_axi_wready = !w_have;
  assign s_axi_arready = !s_axi_rvalid;

  // Write channel acceptance and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CRS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux
  reg [31:0] rd_val;
  reg rd_ok;
  always @* begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `CRS_OFF_INSTR: rd_val = {16'h0000, instr};
      `CRS_OFF_STAT: rd_val = {31'h00000000, busy};
      `CRS_OFF_PC: rd_val = {11'h000, pc};
      `CRS_OFF_WREG: rd_val = {24'h000000, working_reg};
      `CRS_OFF_FLAGS: rd_val = {24'h000000, flags};
      `CRS_OFF_BANK: rd_val = {24'h000000, bank_select_reg};
      `CRS_OFF_WSHAD: rd_val = {24'h000000, working_reg_shadow};
      `CRS_OFF_FSHAD: rd_val = {24'h000000, flags_shadow};
      `CRS_OFF_BSHAD: rd_val = {24'h000000, bank_select_shadow};
      `CRS_OFF_INTEN: rd_val = {29'h00000000, ret_sets_low, low_prio_global_int_en,
                                high_prio_global_int_en};
      `CRS_OFF_TOS: rd_val = {11'h000, stack_top_value};
      `CRS_OFF_SPTR: rd_val = {27'h0000000, sp};
      `CRS_OFF_LATCH: rd_val = {16'h0000, pc_upper_latch, pc_high_latch};
      default: rd_ok = 1'b0;
    endcase
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CRS_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Return stack, pointer and storage
  always @(posedge aclk) begin
    if (!aresetn || soft_rst) begin // see [RL7]
      sp <= 5'h00;
    end else if (do_push) begin
      stack[sp_up] <= pc_plus2; // see [RL3] see [RL4] see [RL5]
      sp <= sp_up; // see [RL14]
    end else if (do_pop) begin
      if (sp != 5'h00) begin
        sp <= sp_dn; // see [RL2] see [RL14]
      end
    end else if (sw_we && (aw_addr == `CRS_OFF_TOS) && (sp != 5'h00)) begin
      stack[sp] <= w_data[`CRS_PC_W-1:0];
    end
  end

  // Instruction sequencer and architectural registers
  always @(posedge aclk) begin
    if (!aresetn || soft_rst) begin // see [RL7]
      instr <= `CRS_RST_INSTR;
      busy <= 1'b0;
      phase <= `CRS_PH_Q1;
      second <= 1'b0;
      pc <= `CRS_RST_PC;
      working_reg <= `CRS_RST_BYTE;
      flags <= `CRS_RST_BYTE;
      bank_select_reg <= `CRS_RST_BYTE;
      working_reg_shadow <= `CRS_RST_BYTE;
      flags_shadow <= `CRS_RST_BYTE;
      bank_select_shadow <= `CRS_RST_BYTE;
      high_prio_global_int_en <= 1'b0;
      low_prio_global_int_en <= 1'b0;
      ret_sets_low <= 1'b0;
      pc_high_latch <= `CRS_RST_BYTE;
      pc_upper_latch <= `CRS_RST_BYTE;
    end else if (busy) begin
      phase <= phase + 2'h1;
      if (phase == `CRS_PH_Q4) begin
        if (!second && is_two_cycle(instr)) begin
          second <= 1'b1; // see [RL5] see [RL15]
        end else begin
          busy <= 1'b0;
          second <= 1'b0;
        end
      end
      if (at_q4) begin
        pc <= next_pc; // see [RL6] see [RL8]
        if (op_literal_return_op) begin
          working_reg <= instr[7:0]; // see [RL11]
        end
        if (op_interrupt_return_op) begin
          if (ret_sets_low) begin
            low_prio_global_int_en <= 1'b1; // see [RL9]
          end else begin
            high_prio_global_int_en <= 1'b1; // see [RL9]
          end
        end
        if ((op_interrupt_return_op || op_return) && shadow_sel) begin
          working_reg <= working_reg_shadow; // see [RL10] see [RL13]
          flags <= flags_shadow;
          bank_select_reg <= bank_select_shadow;
        end
      end
    end else if (sw_we) begin
      case (aw_addr)
        `CRS_OFF_INSTR: begin
          instr <= w_data[15:0];
          busy <= 1'b1;
          phase <= `CRS_PH_Q1;
          second <= 1'b0;
        end
        `CRS_OFF_PC: pc <= {w_data[`CRS_PC_W-1:1], 1'b0};
        `CRS_OFF_WREG: begin
          if (lane0) begin
            working_reg <= wb;
          end
        end
        `CRS_OFF_FLAGS: begin
          if (lane0) begin
            flags <= wb;
          end
        end
        `CRS_OFF_BANK: begin
          if (lane0) begin
            bank_select_reg <= wb;
          end
        end
        `CRS_OFF_WSHAD: begin
          if (lane0) begin
            working_reg_shadow <= wb;
          end
        end
        `CRS_OFF_FSHAD: begin
          if (lane0) begin
            flags_shadow <= wb;
          end
        end
        `CRS_OFF_BSHAD: begin
          if (lane0) begin
            bank_select_shadow <= wb;
          end
        end
        `CRS_OFF_INTEN: begin
          if (lane0) begin
            high_prio_global_int_en <= wb[`CRS_BIT_HIGH_PRIO_GLOBAL_INT_EN];
            low_prio_global_int_en <= wb[`CRS_BIT_LOW_PRIO_GLOBAL_INT_EN];
            ret_sets_low <= wb[`CRS_BIT_RETLOW];
          end
        end
        `CRS_OFF_LATCH: begin
          if (lane0) begin
            pc_high_latch <= wb;
          end
          if (s_axi_wstrb[1]) begin
            pc_upper_latch <= w_data[15:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  wire unused_ok = &{1'b0, s_axi_awprot, s_axi_arprot, s_axi_wstrb[3:2], w_data[31:16]};

endmodule // crs_exec

// file: rtl/crs_exec_consts.vh
// Constants for the return-stack and control-flow executor
// Assumes inclusion by crs_exec.v only
`ifndef CRS_EXEC_CONSTS_VH
`define CRS_EXEC_CONSTS_VH

// Widths and depths
`define CRS_PC_W 21
`define CRS_SP_W 5
`define CRS_STACK_DEPTH 32

// Register byte offsets
`define CRS_OFF_INSTR 8'h00
`define CRS_OFF_STAT 8'h04
`define CRS_OFF_PC 8'h08
`define CRS_OFF_WREG 8'h0c
`define CRS_OFF_FLAGS 8'h10
`define CRS_OFF_BANK 8'h14
`define CRS_OFF_WSHAD 8'h18
`define CRS_OFF_FSHAD 8'h1c
`define CRS_OFF_BSHAD 8'h20
`define CRS_OFF_INTEN 8'h24
`define CRS_OFF_TOS 8'h28
`define CRS_OFF_SPTR 8'h2c
`define CRS_OFF_LATCH 8'h30

// Field positions
`define CRS_BIT_BUSY 0
`define CRS_BIT_HIGH_PRIO_GLOBAL_INT_EN 0
`define CRS_BIT_LOW_PRIO_GLOBAL_INT_EN 1
`define CRS_BIT_RETLOW 2

// Reset values
`define CRS_RST_PC 21'h000000
`define CRS_RST_BYTE 8'h00
`define CRS_RST_INSTR 16'h0000

// Opcodes
`define CRS_OP_POP 16'h0006
`define CRS_OP_PUSH 16'h0005
`define CRS_OP_RESET 16'h00ff
`define CRS_OP_RCALL5 5'h1b
`define CRS_OP_RETFIE15 15'h0008
`define CRS_OP_RETURN15 15'h0009
`define CRS_OP_RETLW8 8'h0c

// Timing: phases per instruction cycle
`define CRS_PH_Q1 2'h0
`define CRS_PH_Q2 2'h1
`define CRS_PH_Q3 2'h2
`define CRS_PH_Q4 2'h3

// AXI responses
`define CRS_RESP_OKAY 2'h0
`define CRS_RESP_SLVERR 2'h2

`endif

// file: test/crs_exec_asserts.sv
// Bus-side checker for the executor
// Assumes binding to crs_exec with one clock and sync reset
`timescale 1ns/1ns
module crs_exec_asserts (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
    else $error("refused read gave data");
  chk_rst_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
    && s_axi_awready && s_axi_wready) else $error("bus not idle after reset");
endmodule // crs_exec_asserts
bind crs_exec crs_exec_asserts u_chk (.*);

// file: test/crs_exec_tb.sv
// Self-checking bench for crs_exec over its register bus
// Assumes the bound checker and no other driver
`timescale 1ns/1ns
module crs_exec_tb;
  reg aclk;
  reg aresetn;
  reg [7:0] awaddr;
  reg [7:0] araddr;
  reg [31:0] wdata;
  reg awvalid, wvalid, bready, arvalid, rready, pend;
  wire awready, wready, arready, bvalid, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  reg [31:0] got;
  integer failures, check_count;
  crs_exec DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  task chk(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // One bus transfer, write when w is set
  task bus(input w, input [7:0] a, input [31:0] v, input [1:0] e);
    integer k;
    begin
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= v;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      pend = 1'b1;
      got = 32'hffffffff;
      for (k = 0; k < 40 && pend; k = k + 1) begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (arready) arvalid <= 1'b0;
        if (bvalid === 1'b1 || rvalid === 1'b1) begin
          got = w ? 32'h0 : rdata;
          chk(w ? bresp : rresp, e);
          bready <= 1'b0;
          rready <= 1'b0;
          pend = 1'b0;
        end
      end
      if (pend) chk(32'h0, 32'h1);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    bus(1'b1, a, v, 2'h0);
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0, 2'h0);
      chk(got, e);
    end
  endtask
  // Poll busy until clear, a stuck busy counts as a mismatch
  task wait_idle;
    integer k;
    begin
      got = 32'h1;
      for (k = 0; k < 20 && got[0] !== 1'b0; k = k + 1) bus(1'b0, 8'h04, 32'h0, 2'h0);
      if (got[0] !== 1'b0) chk(got, 32'h0);
    end
  endtask
  // Issue an opcode and wait for it to finish
  task ex(input [15:0] op);
    begin
      wr(8'h00, {16'h0, op});
      wait_idle;
    end
  endtask
  task t_stack;
    begin
      wr(8'h08, 32'h120);
      ex(16'h0005);
      wr(8'h28, 32'h345a);
      wr(8'h10, 32'h5a);
      wr(8'h08, 32'h124);
      ex(16'h0005);
      rdc(8'h08, 32'h126);
      rdc(8'h28, 32'h126);
      rdc(8'h2c, 32'h2);
      ex(16'h0006);
      rdc(8'h28, 32'h345a);
      rdc(8'h2c, 32'h1);
      rdc(8'h10, 32'h5a);
      ex(16'h0006);
      rdc(8'h2c, 32'h0);
    end
  endtask
  task t_relative_call_op(input [15:0] op, input [31:0] epc);
    begin
      wr(8'h08, 32'h1000);
      ex(op);
      rdc(8'h08, epc);
      rdc(8'h28, 32'h1002);
      ex(16'h0006);
    end
  endtask
  task t_ret(input [15:0] op, input [31:0] ie, input [31:0] ew, input [31:0] ef,
    input [31:0] eb, input [31:0] ei);
    begin
      wr(8'h08, 32'h200);
      ex(16'h0005);
      wr(8'h08, 32'h400);
      wr(8'h0c, 32'h44);
      wr(8'h10, 32'h55);
      wr(8'h14, 32'h66);
      wr(8'h30, 32'h0a0b);
      wr(8'h24, ie);
      ex(op);
      rdc(8'h08, 32'h202);
      rdc(8'h2c, 32'h0);
      rdc(8'h0c, ew);
      rdc(8'h10, ef);
      rdc(8'h14, eb);
      rdc(8'h30, 32'h0a0b);
      rdc(8'h24, ei);
    end
  endtask
  task t_refuse;
    begin
      bus(1'b1, 8'h04, 32'h1, 2'h2);
      bus(1'b1, 8'h40, 32'h1, 2'h2);
      bus(1'b0, 8'h40, 32'h0, 2'h2);
      chk(got, 32'h0);
      wr(8'h00, 32'hd801);
      bus(1'b1, 8'h0c, 32'h99, 2'h2);
      wait_idle;
      rdc(8'h08, 32'h206);
      rdc(8'h28, 32'h204);
      ex(16'h0000);
      rdc(8'h08, 32'h208);
      rdc(8'h0c, 32'ha5);
    end
  endtask
  task t_soft;
    begin
      wr(8'h0c, 32'h77);
      wr(8'h30, 32'h0102);
      ex(16'h0005);
      ex(16'h00ff);
      rdc(8'h0c, 32'h0);
      rdc(8'h08, 32'h0);
      rdc(8'h2c, 32'h0);
      rdc(8'h30, 32'h0);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    #300000;
    failures = failures + 1;
    give_verdict;
  end
  initial begin
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = 0;
    failures = 0;
    check_count = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h08, 32'h0);
    t_stack;
    t_relative_call_op(16'hdc00, 32'h802);
    t_relative_call_op(16'hdbff, 32'h1800);
    wr(8'h18, 32'h11);
    wr(8'h1c, 32'h22);
    wr(8'h20, 32'h33);
    t_ret(16'h0012, 32'h0, 32'h44, 32'h55, 32'h66, 32'h0);
    t_ret(16'h0013, 32'h0, 32'h11, 32'h22, 32'h33, 32'h0);
    t_ret(16'h0010, 32'h4, 32'h44, 32'h55, 32'h66, 32'h6);
    t_ret(16'h0011, 32'h0, 32'h11, 32'h22, 32'h33, 32'h1);
    t_ret(16'h0ca5, 32'h0, 32'ha5, 32'h55, 32'h66, 32'h0);
    t_refuse;
    t_soft;
    give_verdict;
  end
endmodule // crs_exec_tb
